// ### logic/dma_fs_pkg.sv
// shared constants and types for the frame-synchronised dma channel
package dma_fs_pkg;

  // register offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_SRC      = 8'h04;
  localparam logic [7:0] REG_DST      = 8'h08;
  localparam logic [7:0] REG_SPLIT    = 8'h0c;
  localparam logic [7:0] REG_COUNT    = 8'h10;
  localparam logic [7:0] REG_INDEX    = 8'h14;
  localparam logic [7:0] REG_STATUS   = 8'h18;
  localparam logic [7:0] REG_INT_STAT = 8'h1c;
  localparam logic [7:0] REG_INT_CLR  = 8'h20;
  localparam logic [7:0] REG_INT_EN   = 8'h24;

  // control field positions
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_FSYNC_BIT = 1;
  localparam int CTRL_SPLIT_BIT = 2;
  localparam int CTRL_SRC_LSB   = 3;
  localparam int CTRL_DST_LSB   = 5;
  localparam int CTRL_ELEMENT_SIZE_CODE_LSB = 7;
  localparam int CTRL_W         = 9;

  // count and index field positions (low half element, high half frame)
  localparam int HALF_W   = 16;
  localparam int HI_LSB   = 16;

  // interrupt status bits
  localparam int INT_FRAME_BIT = 0;
  localparam int INT_BLOCK_BIT = 1;
  localparam int INT_W         = 2;

  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST  = 9'h000;
  localparam logic [31:0]       WORD_RST  = 32'h0000_0000;
  localparam logic [HALF_W-1:0] CNT_RST   = 16'h0001;
  localparam logic [INT_W-1:0]  INT_RST   = 2'h0;

  // address modes
  localparam logic [1:0] AMODE_FIXED = 2'h0;
  localparam logic [1:0] AMODE_INC   = 2'h1;
  localparam logic [1:0] AMODE_DEC   = 2'h2;
  localparam logic [1:0] AMODE_INDEX = 2'h3;

  // element size codes
  localparam logic [1:0] ELEMENT_SIZE_CODE_WORD = 2'h0;
  localparam logic [1:0] ELEMENT_SIZE_CODE_HALF = 2'h1;
  localparam logic [1:0] ELEMENT_SIZE_CODE_BYTE = 2'h2;

  localparam logic [HALF_W-1:0] CNT_ONE = 16'h0001;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_WSYNC = 5'h02,
    ST_READ  = 5'h04,
    ST_WDATA = 5'h08,
    ST_WRITE = 5'h10
  } state_e;

  // bytes moved per element
  function automatic logic [31:0] element_size_code_bytes(input logic [1:0] code);
    case (code)
      ELEMENT_SIZE_CODE_WORD: element_size_code_bytes = 32'h0000_0004;
      ELEMENT_SIZE_CODE_HALF: element_size_code_bytes = 32'h0000_0002;
      default:    element_size_code_bytes = 32'h0000_0001;
    endcase
  endfunction

endpackage

// ### logic/dma_addr_step.sv
// next-address calculation for one address pointer
`timescale 1ns/1ps
`default_nettype none
module dma_addr_step (
  input  wire logic [31:0] i_addr,
  input  wire logic [1:0]  i_mode,
  input  wire logic [1:0]  i_element_size_code,
  input  wire logic [15:0] i_elem_idx,
  input  wire logic [15:0] i_frame_idx,
  input  wire logic        i_use_frame,
  output logic      [31:0] o_next
);
  logic [15:0] idx;
  logic [31:0] idx_ext;
  logic [31:0] step;

  // index counts bytes regardless of element size
  assign idx     = i_use_frame ? i_frame_idx : i_elem_idx;
  assign idx_ext = {{16{idx[15]}}, idx};
  assign step    = (i_mode == dma_fs_pkg::AMODE_INDEX) ? idx_ext
                 : dma_fs_pkg::element_size_code_bytes(i_element_size_code);
  assign o_next  = (i_mode == dma_fs_pkg::AMODE_FIXED) ? i_addr
                 : (i_mode == dma_fs_pkg::AMODE_DEC)   ? i_addr - step
                 : i_addr + step;
endmodule // dma_addr_step
`default_nettype wire

// ### logic/dma_frame_count.sv
// element and frame counters of the channel
`timescale 1ns/1ps
`default_nettype none
module dma_frame_count (
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset,
  input  wire logic        i_load,
  input  wire logic        i_step,
  input  wire logic [15:0] i_elem_cnt,
  input  wire logic [15:0] i_frame_cnt,
  output logic             o_last_elem,
  output logic             o_last_frame,
  output logic      [15:0] o_elem_left
);
  logic [15:0] elem_ff;
  logic [15:0] frame_ff;
  logic [15:0] nxt_elem;
  logic [15:0] nxt_frame;

  assign o_last_elem  = (elem_ff <= dma_fs_pkg::CNT_ONE);
  assign o_last_frame = (frame_ff <= dma_fs_pkg::CNT_ONE);
  assign o_elem_left  = elem_ff;

  // reload element count for the next frame
  assign nxt_elem  = i_load ? i_elem_cnt
                   : (i_step & o_last_elem) ? i_elem_cnt
                   : i_step ? elem_ff - dma_fs_pkg::CNT_ONE : elem_ff;
  assign nxt_frame = i_load ? i_frame_cnt
                   : (i_step & o_last_elem) ? frame_ff - dma_fs_pkg::CNT_ONE : frame_ff;

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      elem_ff  <= dma_fs_pkg::CNT_RST;
      frame_ff <= dma_fs_pkg::CNT_RST;
    end else begin
      elem_ff  <= nxt_elem;
      frame_ff <= nxt_frame;
    end
  end
endmodule // dma_frame_count
`default_nettype wire

// ### logic/dma_fs_channel.sv
// one dma channel with frame sync, split mode and indexed addressing
//
// How it works
// - In frame-sync mode the read sync latch is cleared as soon as the first read of the synchronised frame starts.
// - With destination mode 11b the destination steps by element index, and by frame index after a frame's last element.
// - In split mode the frame index reaches the destination only on the receive part's last element of a frame.
// - Each end of frame sets the frame end flag once, also in split mode, and it can raise the interrupt.
// - Element size code 00b makes every read and write a full 32-bit word.
// - In indexed mode the address moves by the index value in bytes, whatever the element size.
// - Increment mode moves the address by the element size after each element.
`timescale 1ns/1ps
`default_nettype none
module dma_fs_channel (
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic      [31:0] o_reg_rdata,
  input  wire logic        i_read_sync,
  output logic             o_mem_rd,
  output logic             o_mem_wr,
  output logic      [31:0] o_mem_addr,
  output logic      [31:0] o_mem_wdata,
  output logic      [1:0]  o_element_size_code,
  input  wire logic        i_mem_rd_valid,
  input  wire logic [31:0] i_mem_rd_data,
  output logic      [1:0]  o_channel_action_pins,
  output logic             o_irq
);

  // software registers
  logic [dma_fs_pkg::CTRL_W-1:0] ctrl_ff;
  logic [31:0]                   src_ff;
  logic [31:0]                   dst_ff;
  logic [31:0]                   split_ff;
  logic [31:0]                   count_ff;
  logic [31:0]                   index_ff;
  logic [dma_fs_pkg::INT_W-1:0]  int_stat_ff;
  logic [dma_fs_pkg::INT_W-1:0]  int_en_ff;

  // channel state
  dma_fs_pkg::state_e state_ff;
  dma_fs_pkg::state_e nxt_state;
  logic               read_sync_latch_ff;
  logic               rx_phase_ff;
  logic               first_rd_ff;
  logic [31:0]        data_ff;

  // output flops
  logic        mem_rd_ff;
  logic        mem_wr_ff;
  logic [31:0] mem_addr_ff;
  logic [31:0] mem_wdata_ff;
  logic [31:0] rdata_ff;
  logic        irq_ff;
  logic [1:0]  action_ff;

  // decode
  logic wr_ctrl;
  logic wr_src_reg;
  logic wr_dst_reg;
  logic wr_split;
  logic wr_count;
  logic wr_index;
  logic wr_int_clr;
  logic wr_int_en;
  logic start;
  logic fsync_en;
  logic split_en;
  logic [1:0] src_mode;
  logic [1:0] dst_mode;
  logic [1:0] element_size_code;

  assign wr_ctrl    = i_reg_wr & (i_reg_addr == dma_fs_pkg::REG_CTRL);
  assign wr_src_reg = i_reg_wr & (i_reg_addr == dma_fs_pkg::REG_SRC);
  assign wr_dst_reg = i_reg_wr & (i_reg_addr == dma_fs_pkg::REG_DST);
  assign wr_split   = i_reg_wr & (i_reg_addr == dma_fs_pkg::REG_SPLIT);
  assign wr_count   = i_reg_wr & (i_reg_addr == dma_fs_pkg::REG_COUNT);
  assign wr_index   = i_reg_wr & (i_reg_addr == dma_fs_pkg::REG_INDEX);
  assign wr_int_clr = i_reg_wr & (i_reg_addr == dma_fs_pkg::REG_INT_CLR);
  assign wr_int_en  = i_reg_wr & (i_reg_addr == dma_fs_pkg::REG_INT_EN);

  assign fsync_en          = ctrl_ff[dma_fs_pkg::CTRL_FSYNC_BIT];
  assign split_en          = ctrl_ff[dma_fs_pkg::CTRL_SPLIT_BIT];
  assign src_mode          = ctrl_ff[dma_fs_pkg::CTRL_SRC_LSB +: 2];
  assign dst_mode          = ctrl_ff[dma_fs_pkg::CTRL_DST_LSB +: 2];
  assign element_size_code = ctrl_ff[dma_fs_pkg::CTRL_ELEMENT_SIZE_CODE_LSB +: 2];
  assign start = wr_ctrl & i_reg_wdata[dma_fs_pkg::CTRL_START_BIT] & (state_ff == dma_fs_pkg::ST_IDLE);

  // state decode
  logic st_idle;
  logic st_read;
  logic st_write;
  logic tx_part;
  logic elem_done;
  logic last_elem;
  logic last_frame;
  logic frame_end;
  logic block_end;
  logic src_step;
  logic dst_step;
  logic latch_clr;

  assign st_idle   = (state_ff == dma_fs_pkg::ST_IDLE);
  assign st_read   = (state_ff == dma_fs_pkg::ST_READ);
  assign st_write  = (state_ff == dma_fs_pkg::ST_WRITE);
  assign tx_part   = split_en & ~rx_phase_ff;
  // an element is done after its write, or after the receive part in split mode
  assign elem_done = st_write & ~tx_part;
  assign frame_end = elem_done & last_elem;
  assign block_end = frame_end & last_frame;
  // source moves after its own read part; destination only after the receive part
  assign src_step  = st_write & (~split_en | tx_part);
  assign dst_step  = elem_done;
  assign latch_clr = st_read & first_rd_ff & fsync_en;

  // address steppers
  logic [31:0] src_next;
  logic [31:0] dst_next;

  dma_addr_step u_src_step (
    .i_addr      (src_ff),
    .i_mode      (src_mode),
    .i_element_size_code     (element_size_code),
    .i_elem_idx  (index_ff[dma_fs_pkg::HALF_W-1:0]),
    .i_frame_idx (index_ff[dma_fs_pkg::HI_LSB +: dma_fs_pkg::HALF_W]),
    .i_use_frame (last_elem),
    .o_next      (src_next)
  );

  dma_addr_step u_dst_step (
    .i_addr      (dst_ff),
    .i_mode      (dst_mode),
    .i_element_size_code     (element_size_code),
    .i_elem_idx  (index_ff[dma_fs_pkg::HALF_W-1:0]),
    .i_frame_idx (index_ff[dma_fs_pkg::HI_LSB +: dma_fs_pkg::HALF_W]),
    .i_use_frame (last_elem),
    .o_next      (dst_next)
  );

  dma_frame_count u_count (
    .i_sys_clk    (i_sys_clk),
    .i_reset      (i_reset),
    .i_load       (start),
    .i_step       (elem_done),
    .i_elem_cnt   (count_ff[dma_fs_pkg::HALF_W-1:0]),
    .i_frame_cnt  (count_ff[dma_fs_pkg::HI_LSB +: dma_fs_pkg::HALF_W]),
    .o_last_elem  (last_elem),
    .o_last_frame (last_frame),
    .o_elem_left  ()
  );

  // sequencing
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      dma_fs_pkg::ST_IDLE: begin
        if (start) begin
          nxt_state = i_reg_wdata[dma_fs_pkg::CTRL_FSYNC_BIT] ? dma_fs_pkg::ST_WSYNC : dma_fs_pkg::ST_READ;
        end
      end
      dma_fs_pkg::ST_WSYNC: begin
        if (read_sync_latch_ff) begin
          nxt_state = dma_fs_pkg::ST_READ;
        end
      end
      dma_fs_pkg::ST_READ: begin
        nxt_state = dma_fs_pkg::ST_WDATA;
      end
      dma_fs_pkg::ST_WDATA: begin
        if (i_mem_rd_valid) begin
          nxt_state = dma_fs_pkg::ST_WRITE;
        end
      end
      dma_fs_pkg::ST_WRITE: begin
        if (block_end) begin
          nxt_state = dma_fs_pkg::ST_IDLE;
        end else if (frame_end & fsync_en) begin
          nxt_state = dma_fs_pkg::ST_WSYNC;
        end else begin
          nxt_state = dma_fs_pkg::ST_READ;
        end
      end
      default: begin
        nxt_state = dma_fs_pkg::ST_IDLE;
      end
    endcase
  end

  // next values
  logic [31:0] rd_addr;
  logic [31:0] wr_addr;
  logic        nxt_latch;
  logic        nxt_rx_phase;
  logic        nxt_first_rd;
  logic [dma_fs_pkg::INT_W-1:0] int_set;
  logic [dma_fs_pkg::INT_W-1:0] nxt_int_stat;
  logic [31:0] status_word;
  logic [31:0] nxt_rdata;

  assign rd_addr      = (split_en & rx_phase_ff) ? split_ff : src_ff;
  assign wr_addr      = tx_part ? split_ff : dst_ff;
  // a new sync event beats a same-cycle clear
  assign nxt_latch    = i_read_sync | (read_sync_latch_ff & ~latch_clr);
  assign nxt_rx_phase = start ? 1'b0 : st_write ? (split_en & ~rx_phase_ff) : rx_phase_ff;
  assign nxt_first_rd = (start | frame_end) ? 1'b1 : latch_clr ? 1'b0 : first_rd_ff;
  assign int_set      = {block_end, frame_end};
  assign nxt_int_stat = int_set | (int_stat_ff & ~(wr_int_clr ? i_reg_wdata[dma_fs_pkg::INT_W-1:0]
                                                              : dma_fs_pkg::INT_RST));
  assign status_word  = {25'h0, first_rd_ff, rx_phase_ff, state_ff};
  assign nxt_rdata    = ~i_reg_rd ? dma_fs_pkg::WORD_RST
                      : (i_reg_addr == dma_fs_pkg::REG_CTRL)     ? {23'h0, ctrl_ff}
                      : (i_reg_addr == dma_fs_pkg::REG_SRC)      ? src_ff
                      : (i_reg_addr == dma_fs_pkg::REG_DST)      ? dst_ff
                      : (i_reg_addr == dma_fs_pkg::REG_SPLIT)    ? split_ff
                      : (i_reg_addr == dma_fs_pkg::REG_COUNT)    ? count_ff
                      : (i_reg_addr == dma_fs_pkg::REG_INDEX)    ? index_ff
                      : (i_reg_addr == dma_fs_pkg::REG_STATUS)   ? {status_word[31:8], read_sync_latch_ff,
                                                                    status_word[6:0]}
                      : (i_reg_addr == dma_fs_pkg::REG_INT_STAT) ? {30'h0, int_stat_ff}
                      : (i_reg_addr == dma_fs_pkg::REG_INT_EN)   ? {30'h0, int_en_ff}
                      : dma_fs_pkg::WORD_RST;

  // configuration registers; start bit is not kept
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      ctrl_ff  <= dma_fs_pkg::CTRL_RST;
      split_ff <= dma_fs_pkg::WORD_RST;
      count_ff <= {dma_fs_pkg::CNT_RST, dma_fs_pkg::CNT_RST};
      index_ff <= dma_fs_pkg::WORD_RST;
      int_en_ff <= dma_fs_pkg::INT_RST;
    end else begin
      if (wr_ctrl & st_idle) ctrl_ff <= {i_reg_wdata[dma_fs_pkg::CTRL_W-1:1], 1'b0};
      if (wr_split) split_ff <= i_reg_wdata;
      if (wr_count) count_ff <= i_reg_wdata;
      if (wr_index) index_ff <= i_reg_wdata;
      if (wr_int_en) int_en_ff <= i_reg_wdata[dma_fs_pkg::INT_W-1:0];
    end
  end

  // address pointers; software loads them only while idle
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      src_ff <= dma_fs_pkg::WORD_RST;
      dst_ff <= dma_fs_pkg::WORD_RST;
    end else begin
      if (wr_src_reg & st_idle) src_ff <= i_reg_wdata;
      else if (src_step) src_ff <= src_next;
      if (wr_dst_reg & st_idle) dst_ff <= i_reg_wdata;
      else if (dst_step) dst_ff <= dst_next;
    end
  end

  // channel state
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state_ff           <= dma_fs_pkg::ST_IDLE;
      read_sync_latch_ff <= 1'b0;
      rx_phase_ff        <= 1'b0;
      first_rd_ff        <= 1'b0;
      int_stat_ff        <= dma_fs_pkg::INT_RST;
      data_ff            <= dma_fs_pkg::WORD_RST;
    end else begin
      state_ff           <= nxt_state;
      read_sync_latch_ff <= nxt_latch;
      rx_phase_ff        <= nxt_rx_phase;
      first_rd_ff        <= nxt_first_rd;
      int_stat_ff        <= nxt_int_stat;
      if (i_mem_rd_valid & (state_ff == dma_fs_pkg::ST_WDATA)) data_ff <= i_mem_rd_data;
    end
  end

  // registered outputs
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      mem_rd_ff    <= 1'b0;
      mem_wr_ff    <= 1'b0;
      mem_addr_ff  <= dma_fs_pkg::WORD_RST;
      mem_wdata_ff <= dma_fs_pkg::WORD_RST;
      rdata_ff     <= dma_fs_pkg::WORD_RST;
      irq_ff       <= 1'b0;
      action_ff    <= 2'h0;
    end else begin
      mem_rd_ff    <= st_read;
      mem_wr_ff    <= st_write;
      mem_addr_ff  <= st_read ? rd_addr : wr_addr;
      mem_wdata_ff <= data_ff;
      rdata_ff     <= nxt_rdata;
      irq_ff       <= |(nxt_int_stat & int_en_ff);
      action_ff    <= {frame_end, ~(nxt_state == dma_fs_pkg::ST_IDLE)};
    end
  end

  assign o_mem_rd              = mem_rd_ff;
  assign o_mem_wr              = mem_wr_ff;
  assign o_mem_addr            = mem_addr_ff;
  assign o_mem_wdata           = mem_wdata_ff;
  assign o_element_size_code   = ctrl_ff[dma_fs_pkg::CTRL_ELEMENT_SIZE_CODE_LSB +: 2];
  assign o_reg_rdata           = rdata_ff;
  assign o_irq                 = irq_ff;
  assign o_channel_action_pins = action_ff;

endmodule // dma_fs_channel
`default_nettype wire

// ### verif/dma_fs_channel_sva.sv
// port assertions for the dma channel
`timescale 1ns/1ps
`default_nettype none
module dma_fs_channel_sva (
  input wire logic        i_sys_clk,
  input wire logic        i_reset,
  input wire logic [7:0]  i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic        i_reg_wr,
  input wire logic        i_read_sync,
  input wire logic        o_mem_rd,
  input wire logic        o_mem_wr,
  input wire logic [1:0]  o_element_size_code,
  input wire logic        i_mem_rd_valid,
  input wire logic [1:0]  o_channel_action_pins,
  input wire logic        o_irq
);
  logic       pend_ff;
  logic       fs_ff;
  logic       en_ff;
  logic [1:0] esz_ff;
  wire        ctrl_wr = i_reg_wr && i_reg_addr == dma_fs_pkg::REG_CTRL && !o_channel_action_pins[0];
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      pend_ff <= 1'b0;
      fs_ff <= 1'b0;
      en_ff <= 1'b0;
      esz_ff <= 2'h0;
    end else begin
      pend_ff <= o_mem_rd | (pend_ff & ~i_mem_rd_valid);
      fs_ff <= ctrl_wr ? i_reg_wdata[1] : fs_ff;
      esz_ff <= ctrl_wr ? i_reg_wdata[8:7] : esz_ff;
      en_ff <= (i_reg_wr && i_reg_addr == dma_fs_pkg::REG_INT_EN) ? i_reg_wdata[0] : en_ff;
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  sequence s_take;
    pend_ff && i_mem_rd_valid;
  endsequence
  sequence s_fill;
    !o_mem_wr ##1 o_mem_wr;
  endsequence
  AST_WR_LATE: assert property (s_take |=> s_fill)
    else $error("write not two cycles after read data");
  AST_WR_NEEDS_DATA: assert property (o_mem_wr |-> $past(i_mem_rd_valid, 2))
    else $error("write without read data");
  AST_NO_RD_IN_WAIT: assert property (pend_ff |-> !o_mem_rd)
    else $error("read issued while data outstanding");
  AST_BUSY_ON_RD: assert property (o_mem_rd |-> o_channel_action_pins[0])
    else $error("read while channel idle");
  AST_FRAME_PULSE: assert property (o_channel_action_pins[1] |=> !o_channel_action_pins[1])
    else $error("frame end pulse longer than one cycle");
  AST_FRAME_IRQ: assert property (en_ff && o_channel_action_pins[1] |-> ##[0:2] o_irq)
    else $error("frame end did not raise interrupt");
  AST_SYNC_READ: assert property (fs_ff && i_read_sync |-> ##[1:4] o_mem_rd)
    else $error("sync did not start a read");
  AST_ELEMENT_SIZE_CODE_OUT: assert property (o_element_size_code == esz_ff)
    else $error("element size code differs from control");
endmodule // dma_fs_channel_sva
bind dma_fs_channel dma_fs_channel_sva chk (.i_sys_clk, .i_reset, .i_reg_addr, .i_reg_wdata, .i_reg_wr,
  .i_read_sync, .o_mem_rd, .o_mem_wr, .o_element_size_code, .i_mem_rd_valid, .o_channel_action_pins, .o_irq);
`default_nettype wire

// ### verif/dma_mem_model.sv
// memory model answering the channel's reads after a set delay
`timescale 1ns/1ps
`default_nettype none
module dma_mem_model (
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset,
  input  wire logic        i_rd,
  input  wire logic [31:0] i_addr,
  input  wire logic [3:0]  i_delay,
  output logic             o_valid,
  output logic      [31:0] o_data
);
  logic        busy_ff;
  logic [3:0]  cnt_ff;
  logic [31:0] addr_ff;
  always_ff @(posedge i_sys_clk) begin
    o_valid <= 1'b0;
    o_data <= ~o_data;
    if (i_reset) begin
      busy_ff <= 1'b0;
      o_data <= 32'h0;
    end else if (i_rd) begin
      busy_ff <= 1'b1;
      cnt_ff <= i_delay;
      addr_ff <= i_addr;
    end else if (busy_ff && cnt_ff != 4'h0) begin
      cnt_ff <= cnt_ff - 4'h1;
    end else if (busy_ff) begin
      busy_ff <= 1'b0;
      o_valid <= 1'b1;
      o_data <= {~addr_ff[15:0], addr_ff[15:0]};
    end
  end
endmodule // dma_mem_model
`default_nettype wire

// ### verif/tb_dma_frame_sync_split_indexing.sv
// self-checking bench for the frame-synchronised dma channel
`timescale 1ns/1ps
`default_nettype none
module tb_dma_frame_sync_split_indexing;
  typedef struct packed {
    logic [8:0]  ctrl;
    logic [31:0] cnt;
    logic [31:0] idx;
  } row_s;
  logic        i_sys_clk = 1'b0;
  logic        i_reset = 1'b1;
  logic [7:0]  i_reg_addr = 8'h00;
  logic [31:0] i_reg_wdata = 32'h0;
  logic        i_reg_wr = 1'b0;
  logic        i_reg_rd = 1'b0;
  logic        i_read_sync = 1'b0;
  logic [3:0]  mem_delay = 4'h0;
  logic [31:0] o_reg_rdata, o_mem_addr, o_mem_wdata, mem_data, rd_val;
  logic        o_mem_rd, o_mem_wr, o_irq, mem_valid;
  logic [1:0]  o_element_size_code, o_channel_action_pins;
  int          fails = 0;
  int          checks_done = 0;
  int          pulses = 0;
  int          wrs = 0;
  logic [7:0]  rst_a [5] = '{8'h00, 8'h10, 8'h18, 8'h1c, 8'h40};
  logic [31:0] rst_v [5] = '{32'h0, 32'h0001_0001, 32'h1, 32'h0, 32'h0};
  row_s        rows [6] = '{'{9'h008, 32'h0001_0003, 32'h0}, '{9'h028, 32'h0002_0002, 32'h0},
    '{9'h0c8, 32'h0002_0002, 32'h0}, '{9'h068, 32'h0002_0003, 32'h0008_0002},
    '{9'h068, 32'h0001_0004, 32'hfffd_0001}, '{9'h06c, 32'h0002_0002, 32'h0010_0004}};
  dma_fs_channel uut (.i_sys_clk, .i_reset, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata,
    .i_read_sync, .o_mem_rd, .o_mem_wr, .o_mem_addr, .o_mem_wdata, .o_element_size_code,
    .i_mem_rd_valid(mem_valid), .i_mem_rd_data(mem_data), .o_channel_action_pins, .o_irq);
  dma_mem_model mem (.i_sys_clk, .i_reset, .i_rd(o_mem_rd), .i_addr(o_mem_addr), .i_delay(mem_delay),
    .o_valid(mem_valid), .o_data(mem_data));
  initial forever #25 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) begin
    pulses = pulses + (o_channel_action_pins[1] === 1'b1 ? 1 : 0);
    wrs = wrs + (o_mem_wr === 1'b1 ? 1 : 0);
  end
  function automatic logic [31:0] pat(input logic [31:0] a);
    return {~a[15:0], a[15:0]};
  endfunction
  function automatic logic [31:0] esz(input logic [1:0] c);
    return c == 2'h0 ? 32'h4 : c == 2'h1 ? 32'h2 : 32'h1;
  endfunction
  function automatic logic [31:0] dstep(input row_s r, input bit last);
    case (r.ctrl[6:5])
      2'h0: return 32'h0;
      2'h1: return esz(r.ctrl[8:7]);
      2'h2: return -esz(r.ctrl[8:7]);
      default: return last ? {{16{r.idx[31]}}, r.idx[31:16]} : {{16{r.idx[15]}}, r.idx[15:0]};
    endcase
  endfunction
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_sys_clk);
    i_reg_wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge i_sys_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_sys_clk);
    i_reg_rd <= 1'b0;
    #1 rd_val = o_reg_rdata;
  endtask
  // 0 write pulse, 1 read pulse, 2 channel idle
  task automatic wait_for(input int which);
    int n;
    n = 0;
    do begin
      @(posedge i_sys_clk);
      #1 n++;
    end while (!(which == 0 ? o_mem_wr === 1'b1 : which == 1 ? o_mem_rd === 1'b1
                 : o_channel_action_pins[0] === 1'b0) && n < 300);
    if (n >= 300) begin
      fails++;
      give_verdict();
    end
  endtask
  task automatic run_row(input row_s r, input logic [3:0] dly);
    logic [31:0] s, d;
    int f, e;
    s = 32'h100;
    d = 32'h200;
    @(posedge i_sys_clk);
    mem_delay <= dly;
    wr_reg(dma_fs_pkg::REG_SRC, s);
    wr_reg(dma_fs_pkg::REG_DST, d);
    wr_reg(dma_fs_pkg::REG_SPLIT, 32'h300);
    wr_reg(dma_fs_pkg::REG_COUNT, r.cnt);
    wr_reg(dma_fs_pkg::REG_INDEX, r.idx);
    pulses = 0;
    wrs = 0;
    wr_reg(dma_fs_pkg::REG_CTRL, {23'h0, r.ctrl} | 32'h1);
    #1 cmp({30'h0, o_element_size_code}, {30'h0, r.ctrl[8:7]});
    for (f = 0; f < r.cnt[31:16]; f++) begin
      if (r.ctrl[1]) begin
        rd_reg(dma_fs_pkg::REG_STATUS);
        cmp(rd_val & 32'h9f, 32'h02);
        @(posedge i_sys_clk);
        i_read_sync <= 1'b1;
        @(posedge i_sys_clk);
        i_read_sync <= 1'b0;
        wait_for(1);
        rd_reg(dma_fs_pkg::REG_STATUS);
        cmp(rd_val & 32'h9f, 32'h08);
      end
      for (e = 0; e < r.cnt[15:0]; e++) begin
        wait_for(0);
        if (r.ctrl[2]) begin
          cmp(o_mem_addr, 32'h300);
          cmp(o_mem_wdata, pat(s));
          s += esz(r.ctrl[8:7]);
          wait_for(0);
        end
        cmp(o_mem_addr, d);
        cmp(o_mem_wdata, pat(r.ctrl[2] ? 32'h300 : s));
        s += r.ctrl[2] ? 32'h0 : esz(r.ctrl[8:7]);
        d += dstep(r, e + 1 == r.cnt[15:0]);
      end
    end
    wait_for(2);
    repeat (2) @(posedge i_sys_clk);
    cmp(pulses, r.cnt[31:16]);
    cmp(wrs, r.cnt[31:16] * r.cnt[15:0] * (r.ctrl[2] ? 2 : 1));
    rd_reg(dma_fs_pkg::REG_INT_STAT);
    cmp(rd_val, 32'h3);
    cmp({31'h0, o_irq}, 32'h1);
    wr_reg(dma_fs_pkg::REG_INT_CLR, 32'h3);
    repeat (2) @(posedge i_sys_clk);
    #1 cmp({31'h0, o_irq}, 32'h0);
  endtask
  initial begin
    repeat (20) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    for (int k = 0; k < 5; k++) begin
      rd_reg(rst_a[k]);
      cmp(rd_val, rst_v[k]);
    end
    // status is read-only
    wr_reg(dma_fs_pkg::REG_STATUS, 32'hff);
    rd_reg(dma_fs_pkg::REG_STATUS);
    cmp(rd_val, 32'h1);
    wr_reg(dma_fs_pkg::REG_INT_EN, 32'h1);
    foreach (rows[k]) run_row(rows[k], 4'(k % 3));
    run_row('{9'h02a, 32'h0002_0002, 32'h0}, 4'h6);
    // reset in mid-transfer returns the channel to idle
    wr_reg(dma_fs_pkg::REG_COUNT, 32'h0002_0002);
    wr_reg(dma_fs_pkg::REG_CTRL, 32'h0000_0029);
    wait_for(1);
    @(posedge i_sys_clk);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    #1 cmp({30'h0, o_channel_action_pins}, 32'h0);
    cmp({31'h0, o_mem_rd}, 32'h0);
    rd_reg(dma_fs_pkg::REG_STATUS);
    cmp(rd_val, 32'h1);
    rd_reg(dma_fs_pkg::REG_COUNT);
    cmp(rd_val, 32'h0001_0001);
    give_verdict();
  end
endmodule // tb_dma_frame_sync_split_indexing
`default_nettype wire
